/* core/tmr_timer0.sv */
// 8-bit timer/counter 0 with APB registers and external count pin.
// Assumes APB master on clk; count pin is asynchronous.
`timescale 1ns/1ns
`include "tmr_cfg.svh"
module tmr_timer0 (
    input  wire logic        clk,             // System clock 50 MHz
    input  wire logic        sys_rst,         // Async reset, active high
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB enable
    input  wire logic        pwrite,          // APB write
    input  wire logic [11:0] paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error
    input  wire logic        ext_count_pin_a, // External count pin
    input  wire logic        globalIrqEn,     // Status register I-bit
    input  wire logic        cmpAck,          // Compare vector taken
    input  wire logic        ovfAck,          // Overflow vector taken
    output logic             cmpIrq,          // Compare request
    output logic             ovfIrq,          // Overflow request
    output logic             cmp_a_wave_out   // Waveform output
);
    tmr_presc_if presc ();

    logic [7:0]  counter_value_reg;
    logic [7:0]  counter_value_next;
    logic [7:0]  compare_value_a_reg;
    logic [1:0]  irqMask_reg;
    logic [1:0]  flags_reg;
    logic [1:0]  flags_next;
    logic        sync_hold_mode_reg;
    logic        shared_presc_reset_reg;
    logic        shared_presc_reset_next;
    logic [2:0]  clk_select_field_reg;
    logic [1:0]  waveMode_reg;
    logic [1:0]  cmpOutMode_reg;
    logic        countDown_reg;
    logic        blockCmp_reg;
    logic        blockCmp_next;
    logic        pinSync1_reg;
    logic        pinSync2_reg;
    logic        pinLast_reg;
    logic        wave_reg;
    logic        wave_next;
    logic [31:0] rdata_next;
    logic        ready_reg;
    logic        cmpIrq_reg;
    logic        ovfIrq_reg;

    tmr_prescaler u_presc (
        .clk     (clk),
        .sys_rst (sys_rst),
        .presc   (presc.psc)
    );

    // APB decode; every access answers after one wait state
    wire access     = psel && penable && !ready_reg;
    wire wrAccess   = access && pwrite;
    wire hitCount   = paddr == `TMR_OFS_COUNT;
    wire hitCompare = paddr == `TMR_OFS_COMPARE;
    wire hitMask    = paddr == `TMR_OFS_MASK;
    wire hitFlags   = paddr == `TMR_OFS_FLAGS;
    wire hitGlobal  = paddr == `TMR_OFS_GLOBAL;
    wire hitControl = paddr == `TMR_OFS_CONTROL;
    wire hitAny     = hitCount | hitCompare | hitMask | hitFlags
                    | hitGlobal | hitControl;
    wire wrCount    = wrAccess && hitCount;
    wire wrGlobal   = wrAccess && hitGlobal;

    // Edge detector on the synchronised pin
    wire riseEdge = pinSync2_reg && !pinLast_reg;
    wire fallEdge = !pinSync2_reg && pinLast_reg;

    // Clock select: direct, prescaler tap, external edge or none
    tmr_pkg::tmr_cs_e csSel;
    assign csSel = tmr_pkg::tmr_cs_e'(clk_select_field_reg);
    wire prescHalt = shared_presc_reset_reg;
    wire tapTick =
        (csSel == tmr_pkg::TMR_CS_DIV8)  ? presc.tapPulse[0] :
        (csSel == tmr_pkg::TMR_CS_DIV64) ? presc.tapPulse[1] :
        (csSel == tmr_pkg::TMR_CS_D256)  ? presc.tapPulse[2] :
        (csSel == tmr_pkg::TMR_CS_D1024) ? presc.tapPulse[3] :
        1'b0;
    wire extTick =
        (csSel == tmr_pkg::TMR_CS_EXTR) ? riseEdge :
        (csSel == tmr_pkg::TMR_CS_EXTF) ? fallEdge : 1'b0;
    wire timer_tick = !prescHalt &&
        ((csSel == tmr_pkg::TMR_CS_DIV1) || tapTick || extTick);

    // Counting sequence per waveform mode
    wire isPc  = waveMode_reg == tmr_pkg::TMR_WG_PCPWM;
    wire isCtc = waveMode_reg == tmr_pkg::TMR_WG_CTC;
    wire match = counter_value_reg == compare_value_a_reg;
    wire cmpHit = timer_tick && match && !blockCmp_reg;
    wire atMax = counter_value_reg == `TMR_MAX;
    wire pcTurnBottom = isPc && countDown_reg &&
        counter_value_reg == 8'h01;
    wire ovfHit = timer_tick &&
        (isPc ? pcTurnBottom : atMax);
    wire pcTurnTop = isPc && !countDown_reg && atMax;

    // Counter next value; a software write wins over a tick
    always_comb begin
        counter_value_next = counter_value_reg;
        if (wrCount) begin
            counter_value_next = pwdata[7:0];
        end else if (timer_tick) begin
            if (isCtc && match) begin
                counter_value_next = `TMR_BOTTOM;
            end else if (isPc && countDown_reg) begin
                counter_value_next = counter_value_reg - 8'h01;
            end else if (pcTurnTop) begin
                counter_value_next = counter_value_reg - 8'h01;
            end else begin
                counter_value_next = counter_value_reg + 8'h01;
            end
        end
    end

    // Match blocking armed by counter write, spent on the next tick
    assign blockCmp_next = wrCount ? 1'b1 :
                           timer_tick ? 1'b0 : blockCmp_reg;

    // Flags: hardware set wins over vector ack and write-one clear
    wire [1:0] flagClr = ({2{wrAccess && hitFlags}} & pwdata[1:0])
                       | {cmpAck, ovfAck};
    assign flags_next[`TMR_BIT_CMP] = cmpHit |
        (flags_reg[`TMR_BIT_CMP] & !flagClr[`TMR_BIT_CMP]);
    assign flags_next[`TMR_BIT_OVF] = ovfHit |
        (flags_reg[`TMR_BIT_OVF] & !flagClr[`TMR_BIT_OVF]);

    // Prescaler reset: held in sync mode, self-clearing otherwise
    wire syncNext = wrGlobal ? pwdata[`TMR_BIT_SYNC] : sync_hold_mode_reg;
    assign shared_presc_reset_next =
        wrGlobal ? (pwdata[`TMR_BIT_PRST] && pwdata[`TMR_BIT_SYNC]) :
        (shared_presc_reset_reg && sync_hold_mode_reg);
    assign presc.prescRst = (wrGlobal && pwdata[`TMR_BIT_PRST])
                          || shared_presc_reset_reg;

    // Waveform output on compare match, and at max in fast PWM
    always_comb begin
        wave_next = wave_reg;
        if (cmpHit) begin
            unique case (cmpOutMode_reg)
                2'b00: wave_next = wave_reg;
                2'b01: wave_next = isPc || waveMode_reg ==
                           tmr_pkg::TMR_WG_FPWM ? wave_reg : !wave_reg;
                2'b10: wave_next = isPc && countDown_reg;
                2'b11: wave_next = !(isPc && countDown_reg);
            endcase
        end else if (timer_tick && atMax &&
                     waveMode_reg == tmr_pkg::TMR_WG_FPWM &&
                     cmpOutMode_reg[1]) begin
            wave_next = !cmpOutMode_reg[0];
        end
    end

    // Read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hitCount) begin
            rdata_next[7:0] = counter_value_reg;
        end else if (hitCompare) begin
            rdata_next[7:0] = compare_value_a_reg;
        end else if (hitMask) begin
            rdata_next[1:0] = irqMask_reg;
        end else if (hitFlags) begin
            rdata_next[1:0] = flags_reg;
        end else if (hitGlobal) begin
            rdata_next[`TMR_BIT_SYNC] = sync_hold_mode_reg;
            rdata_next[`TMR_BIT_PRST] = shared_presc_reset_reg;
        end else if (hitControl) begin
            rdata_next[2:0] = clk_select_field_reg;
            rdata_next[4:3] = waveMode_reg;
            rdata_next[6:5] = cmpOutMode_reg;
        end
    end

    // Pin synchroniser and edge history
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinSync1_reg <= 1'b0;
            pinSync2_reg <= 1'b0;
            pinLast_reg  <= 1'b0;
        end else begin
            pinSync1_reg <= ext_count_pin_a;
            pinSync2_reg <= pinSync1_reg;
            pinLast_reg  <= pinSync2_reg;
        end
    end

    // Counter, flags and direction
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            counter_value_reg <= `TMR_RST_BYTE;
            flags_reg         <= 2'b00;
            blockCmp_reg      <= 1'b0;
            countDown_reg     <= 1'b0;
            wave_reg          <= 1'b0;
        end else begin
            counter_value_reg <= counter_value_next;
            flags_reg         <= flags_next;
            blockCmp_reg      <= blockCmp_next;
            wave_reg          <= wave_next;
            if (!isPc || (timer_tick && pcTurnBottom)) begin
                countDown_reg <= 1'b0;
            end else if (timer_tick && pcTurnTop) begin
                countDown_reg <= 1'b1;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            compare_value_a_reg    <= `TMR_RST_BYTE;
            irqMask_reg            <= 2'b00;
            sync_hold_mode_reg     <= 1'b0;
            shared_presc_reset_reg <= 1'b0;
            clk_select_field_reg   <= 3'b000;
            waveMode_reg           <= 2'b00;
            cmpOutMode_reg         <= 2'b00;
        end else begin
            sync_hold_mode_reg     <= syncNext;
            shared_presc_reset_reg <= shared_presc_reset_next;
            if (wrAccess && hitCompare) begin
                compare_value_a_reg <= pwdata[7:0];
            end
            if (wrAccess && hitMask) begin
                irqMask_reg <= pwdata[1:0];
            end
            if (wrAccess && hitControl) begin
                clk_select_field_reg <= pwdata[2:0];
                waveMode_reg         <= pwdata[4:3];
                cmpOutMode_reg       <= pwdata[6:5];
            end
        end
    end

    // Bus answer and interrupt requests
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ready_reg      <= 1'b0;
            prdata         <= 32'h0000_0000;
            pslverr        <= 1'b0;
            cmpIrq_reg     <= 1'b0;
            ovfIrq_reg     <= 1'b0;
            cmp_a_wave_out <= 1'b0;
        end else begin
            ready_reg      <= access;
            prdata         <= access ? rdata_next : 32'h0000_0000;
            pslverr        <= access && !hitAny;
            cmpIrq_reg     <= globalIrqEn && irqMask_reg[`TMR_BIT_CMP]
                              && flags_next[`TMR_BIT_CMP];
            ovfIrq_reg     <= globalIrqEn && irqMask_reg[`TMR_BIT_OVF]
                              && flags_next[`TMR_BIT_OVF];
            cmp_a_wave_out <= wave_next;
        end
    end

    assign pready = ready_reg;
    assign cmpIrq = cmpIrq_reg;
    assign ovfIrq = ovfIrq_reg;
endmodule

/* include/tmr_cfg.svh */
// Constants for the 8-bit timer with shared prescaler.
// Assumes a 32-bit APB slave on clk at 50 MHz; offsets are byte addresses.
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

`define TMR_OFS_COUNT    12'h000
`define TMR_OFS_COMPARE  12'h004
`define TMR_OFS_MASK     12'h008
`define TMR_OFS_FLAGS    12'h00C
`define TMR_OFS_GLOBAL   12'h010
`define TMR_OFS_CONTROL  12'h014

`define TMR_BIT_CMP      1
`define TMR_BIT_OVF      0
`define TMR_BIT_SYNC     7
`define TMR_BIT_PRST     0

`define TMR_RST_BYTE     8'h00
`define TMR_BOTTOM       8'h00
`define TMR_MAX          8'hFF
`define TMR_PRESC_W      10

`endif

/* include/tmr_pkg.sv */
// Types for the 8-bit timer.
// Assumes tmr_cfg.svh supplies the numeric constants.
package tmr_pkg;
    typedef enum logic [2:0] {
        TMR_CS_STOP  = 3'b000,
        TMR_CS_DIV1  = 3'b001,
        TMR_CS_DIV8  = 3'b010,
        TMR_CS_DIV64 = 3'b011,
        TMR_CS_D256  = 3'b100,
        TMR_CS_D1024 = 3'b101,
        TMR_CS_EXTF  = 3'b110,
        TMR_CS_EXTR  = 3'b111
    } tmr_cs_e;

    typedef enum logic [1:0] {
        TMR_WG_NORMAL = 2'b00,
        TMR_WG_PCPWM  = 2'b01,
        TMR_WG_CTC    = 2'b10,
        TMR_WG_FPWM   = 2'b11
    } tmr_wg_e;
endpackage

/* include/tmr_presc_if.sv */
// Carrier between the timer top and the shared prescaler.
// Assumes one clock; the top drives the reset, the prescaler the taps.
`timescale 1ns/1ns
interface tmr_presc_if;
    logic       prescRst;   // Hold prescaler at zero
    logic [3:0] tapPulse;   // One-cycle tap pulses /8 /64 /256 /1024

    modport ctl (output prescRst, input tapPulse);
    modport psc (input prescRst, output tapPulse);
endinterface

/* core/tmr_prescaler.sv */
// Shared free-running prescaler with four taps.
// Assumes reset from the global control register of the top.
`timescale 1ns/1ns
`include "tmr_cfg.svh"
module tmr_prescaler (
    input  wire logic clk,     // System clock
    input  wire logic sys_rst, // Asynchronous reset, active high
    tmr_presc_if.psc  presc    // Reset in, taps out
);
    logic [`TMR_PRESC_W-1:0] count_reg;
    logic [`TMR_PRESC_W-1:0] count_next;
    logic [3:0]              tap_reg;
    logic [3:0]              tapNext;

    // Count wraps every 1024; taps fire when low bits become zero
    assign count_next = presc.prescRst ? '0 : count_reg + 1'b1;
    assign tapNext[0] = count_next[2:0] == 3'h0 && !presc.prescRst;
    assign tapNext[1] = count_next[5:0] == 6'h00 && !presc.prescRst;
    assign tapNext[2] = count_next[7:0] == 8'h00 && !presc.prescRst;
    assign tapNext[3] = count_next == 10'h000 && !presc.prescRst;
    assign presc.tapPulse = tap_reg;

    // Prescaler state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= '0;
            tap_reg   <= '0;
        end else begin
            count_reg <= count_next;
            tap_reg   <= tapNext;
        end
    end
endmodule

/* testbench/tmr_ext_src.sv */
// Model of the external clock source on the count pin.
// Assumes the bench calls pulses right after a rising clock edge.
`timescale 1ns/1ns
module tmr_ext_src (
    input  wire logic clk, // System clock
    output logic      pin  // Count pin, idles low between bursts
);
    initial pin = 1'b0;
    // Whole pulses, each half at least two system cycles long
    task automatic pulses(input int n, input int half);
        repeat (n) begin
            pin <= 1'b1;
            repeat (half) @(posedge clk);
            pin <= 1'b0;
            repeat (half) @(posedge clk);
        end
    endtask
endmodule

/* testbench/tmr_timer0_assertions.sv */
// Checker for the timer top: bus handshake and request gating.
// Assumes it is bound to tmr_timer0 and sees only its ports.
`timescale 1ns/1ns
module tmr_timer0_chk (
    input wire logic        clk,             // System clock
    input wire logic        sys_rst,         // Async reset
    input wire logic        psel,            // APB select
    input wire logic        penable,         // APB enable
    input wire logic        pwrite,          // APB write
    input wire logic [11:0] paddr,           // APB address
    input wire logic [31:0] pwdata,          // APB write data
    input wire logic [31:0] prdata,          // APB read data
    input wire logic        pready,          // APB ready
    input wire logic        pslverr,         // APB error
    input wire logic        ext_count_pin_a, // Count pin
    input wire logic        globalIrqEn,     // Global enable
    input wire logic        cmpAck,          // Compare vector taken
    input wire logic        ovfAck,          // Overflow vector taken
    input wire logic        cmpIrq,          // Compare request
    input wire logic        ovfIrq,          // Overflow request
    input wire logic        cmp_a_wave_out   // Waveform output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Bus answers: one pulse per access, data only with ready
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held over one cycle");
    a_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered in time");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    a_ready_idle: assert property (!psel |=> !pready)
        else $error("ready while idle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error outside answer");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    // Requests follow the global enable one cycle later
    a_cmp_gate: assert property (!globalIrqEn |=> !cmpIrq)
        else $error("compare request without global enable");
    a_ovf_gate: assert property (!globalIrqEn |=> !ovfIrq)
        else $error("overflow request without global enable");
endmodule

bind tmr_timer0 tmr_timer0_chk u_chk (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_pin_a(ext_count_pin_a),
    .globalIrqEn(globalIrqEn), .cmpAck(cmpAck), .ovfAck(ovfAck),
    .cmpIrq(cmpIrq), .ovfIrq(ovfIrq), .cmp_a_wave_out(cmp_a_wave_out)
);

/* testbench/tmr_timer0_tb_top.sv */
// Self-checking bench for the timer top over APB.
// Assumes tmr_timer0, its checker and the pin source model.
`timescale 1ns/1ns
`include "tmr_cfg.svh"
module timer0_regs_shared_prescaler_tb_top;
    logic        clk, sys_rst, psel, penable, pwrite, glbEn, cmpAck, ovfAck;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, lastRd;
    logic        pready, pslverr, cmpIrq, ovfIrq, pinA, waveOut;
    logic [33:0] expQ[$];
    int          err_count, n_checks, taps[4];
    logic [7:0]  rv;

    tmr_timer0 dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_count_pin_a(pinA), .globalIrqEn(glbEn), .cmpAck(cmpAck),
        .ovfAck(ovfAck), .cmpIrq(cmpIrq), .ovfIrq(ovfIrq),
        .cmp_a_wave_out(waveOut));
    tmr_ext_src u_src (.clk(clk), .pin(pinA));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [33:0] e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr)
            expQ.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            err_count++;
            close_out();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d}, 34'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, 32'h0000_0000, {2'b10, 24'h00_0000, d});
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Read monitor: oldest note against the data on the bus
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            lastRd = prdata;
            if (expQ.size() > 0 && expQ[0][33])
                chk({pslverr, prdata}, expQ[0][32:0]);
            if (expQ.size() > 0)
                void'(expQ.pop_front());
        end
    end

    // Main sequence
    initial begin
        {psel, penable, pwrite, glbEn, cmpAck, ovfAck} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        err_count = 0;
        n_checks = 0;
        taps = '{8, 64, 256, 1024};
        void'($urandom(32'hfd41_cd73));
        sys_rst = 1'b1;
        waitc(8);
        sys_rst <= 1'b0;
        waitc(1);
        rd(`TMR_OFS_MASK, 8'h00);
        apb(1'b0, 12'h018, 32'h0, {2'b11, 32'h0000_0000});
        $display("test reset values done");
        wr(`TMR_OFS_COMPARE, 8'h10);
        wr(`TMR_OFS_COUNT, 8'h10);
        wr(`TMR_OFS_CONTROL, 8'h01);
        waitc(20);
        wr(`TMR_OFS_CONTROL, 8'h00);
        rd(`TMR_OFS_FLAGS, 8'h00);
        wr(`TMR_OFS_COUNT, 8'h00);
        wr(`TMR_OFS_CONTROL, 8'h01);
        waitc(30);
        wr(`TMR_OFS_CONTROL, 8'h00);
        rd(`TMR_OFS_FLAGS, 8'h02);
        wr(`TMR_OFS_COUNT, 8'hF0);
        wr(`TMR_OFS_CONTROL, 8'h01);
        waitc(40);
        wr(`TMR_OFS_CONTROL, 8'h00);
        rd(`TMR_OFS_FLAGS, 8'h03);
        $display("test match and overflow done");
        wr(`TMR_OFS_MASK, 8'h03);
        waitc(3);
        chk({cmpIrq, ovfIrq}, 33'h0);
        glbEn <= 1'b1;
        waitc(3);
        chk({cmpIrq, ovfIrq}, 33'h3);
        wr(`TMR_OFS_FLAGS, 8'h01);
        rd(`TMR_OFS_FLAGS, 8'h02);
        chk({cmpIrq, ovfIrq}, 33'h2);
        cmpAck <= 1'b1;
        waitc(1);
        cmpAck <= 1'b0;
        waitc(3);
        rd(`TMR_OFS_FLAGS, 8'h00);
        chk(cmpIrq, 33'h0);
        wr(`TMR_OFS_MASK, 8'h00);
        $display("test requests done");
        rv = 8'($urandom);
        wr(`TMR_OFS_COUNT, rv);
        waitc(50);
        rd(`TMR_OFS_COUNT, rv);
        wr(`TMR_OFS_GLOBAL, 8'h01);
        rd(`TMR_OFS_GLOBAL, 8'h00);
        wr(`TMR_OFS_COUNT, 8'h00);
        wr(`TMR_OFS_GLOBAL, 8'h81);
        wr(`TMR_OFS_CONTROL, 8'h01);
        waitc(30);
        rd(`TMR_OFS_COUNT, 8'h00);
        rd(`TMR_OFS_GLOBAL, 8'h81);
        wr(`TMR_OFS_GLOBAL, 8'h00);
        rd(`TMR_OFS_GLOBAL, 8'h00);
        wr(`TMR_OFS_CONTROL, 8'h00);
        apb(1'b0, `TMR_OFS_COUNT, 32'h0, 34'h0);
        chk(lastRd != 32'h0, 33'h1);
        $display("test sync hold done");
        for (int s = 0; s < 4; s++) begin
            wr(`TMR_OFS_COUNT, 8'h00);
            wr(`TMR_OFS_CONTROL, 8'(s + 2));
            waitc(4 * taps[s]);
            wr(`TMR_OFS_CONTROL, 8'h00);
            apb(1'b0, `TMR_OFS_COUNT, 32'h0, 34'h0);
            chk(lastRd >= 32'd4 && lastRd <= 32'd5, 33'h1);
        end
        $display("test prescaler taps done");
        wr(`TMR_OFS_COUNT, 8'h00);
        wr(`TMR_OFS_CONTROL, 8'h07);
        waitc(2);
        u_src.pulses(5, 2);
        waitc(6);
        rd(`TMR_OFS_COUNT, 8'h05);
        wr(`TMR_OFS_COUNT, 8'h00);
        wr(`TMR_OFS_CONTROL, 8'h06);
        waitc(2);
        u_src.pulses(3, 3);
        waitc(6);
        rd(`TMR_OFS_COUNT, 8'h03);
        wr(`TMR_OFS_CONTROL, 8'h00);
        $display("test external pin done");
        // Toggle output on the third external tick, where counter meets 2
        wr(`TMR_OFS_COMPARE, 8'h02);
        wr(`TMR_OFS_COUNT, 8'h00);
        wr(`TMR_OFS_CONTROL, 8'h27);
        waitc(2);
        u_src.pulses(3, 2);
        waitc(6);
        chk(waveOut, 33'h1);
        wr(`TMR_OFS_CONTROL, 8'h00);
        // Phase correct: overflow flag only at the turn at bottom
        wr(`TMR_OFS_FLAGS, 8'h03);
        wr(`TMR_OFS_COMPARE, 8'h10);
        wr(`TMR_OFS_COUNT, 8'hF0);
        wr(`TMR_OFS_CONTROL, 8'h09);
        waitc(100);
        rd(`TMR_OFS_FLAGS, 8'h00);
        waitc(200);
        rd(`TMR_OFS_FLAGS, 8'h03);
        wr(`TMR_OFS_CONTROL, 8'h00);
        $display("test waveform and phase correct done");
        close_out();
    end
endmodule
